// file: astx_regs.vh
`ifndef ASTX_REGS_VH
`define ASTX_REGS_VH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ASTX_CONTROL_ONE    12'h000
`define ASTX_CONTROL_TWO    12'h004
`define ASTX_CONTROL_THREE  12'h008
`define ASTX_STATUS_ONE     12'h00c
`define ASTX_STATUS_TWO     12'h010
`define ASTX_DATA_BUFFER    12'h014
// ------------------------------------------------------------
// control_one fields
// ------------------------------------------------------------
`define ASTX_C1_LEN9        4
`define ASTX_C1_UNIT_ON     6
`define ASTX_C1_WAKE_ADDR   3
`define ASTX_C1_PAR_EN      1
`define ASTX_C1_PAR_ODD     0
// ------------------------------------------------------------
// control_two fields
// ------------------------------------------------------------
`define ASTX_C2_TXE_IE      7
`define ASTX_C2_IDLE_IE     4
`define ASTX_C2_TX_ON       3
`define ASTX_C2_RX_ON       2
`define ASTX_C2_STANDBY     1
`define ASTX_C2_BREAK       0
// ------------------------------------------------------------
// control_three fields
// ------------------------------------------------------------
`define ASTX_C3_NINTH_RX    7
`define ASTX_C3_NINTH_TX    6
`define ASTX_C3_FE_IE       1
`define ASTX_C3_PE_IE       0
// ------------------------------------------------------------
// status fields and reset values
// ------------------------------------------------------------
`define ASTX_S1_TXE         7
`define ASTX_S1_TX_DONE     6
`define ASTX_S1_RX_FULL     5
`define ASTX_S1_IDLE        4
`define ASTX_S1_FE          1
`define ASTX_S1_PE          0
`define ASTX_S2_BREAK       1
`define ASTX_S2_RX_BUSY     0
`define ASTX_C1_RST         8'h00
`define ASTX_C2_RST         8'h00
`define ASTX_C3_RST         8'h00
`define ASTX_C3_WR_RST      7'h00
// idle bits counted on rx before the line is called idle
`define ASTX_IDLE_BITS      4'd10
`endif

// file: astx_core.v
`timescale 1ns/1ps
`include "astx_regs.vh"
module astx_core (
  input  wire        pclk,          // bus clock
  input  wire        presetn,       // async reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb access phase
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output reg         pready,        // apb ready
  output reg         pslverr,       // apb error on unmapped address
  input  wire        baud_tick,     // one-cycle bit-rate enable
  input  wire        rx_pin_i,      // receive pin level
  output reg         tx_pin_o,      // transmit pin level
  output reg         tx_pin_oe,     // transmit pin driven
  output reg         rx_pin_oe_n,   // low while unit owns receive pin
  output reg         tx_irq,        // transmitter interrupt request
  output reg         rx_irq,        // receiver interrupt request
  output reg         err_irq        // error interrupt request
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0]  ctl1_q, ctl2_q;
  reg [6:0]  ctl3_q;          // writable part of control_three
  reg        rx_ninth_q;      // received ninth bit, read-only
  reg [7:0]  tx_buf_q, rx_buf_q;
  reg        tx_buf_ninth_q;
  reg        txe_q, tc_q, rxf_q, idle_q, fe_q, pe_q, brk_q;
  reg        fe_arm_q, pe_arm_q;
  reg [10:0] tx_sh_q;
  reg [3:0]  tx_cnt_q;
  reg        tx_busy_q, pre_pend_q, idle_pend_q, tx_end_one_q;
  reg [10:0] rx_sh_q;
  reg [3:0]  rx_cnt_q, rx_idle_q;
  reg        rx_busy_q, idle_armed_q;

  wire unit_on = ctl1_q[`ASTX_C1_UNIT_ON];
  wire len9    = ctl1_q[`ASTX_C1_LEN9];
  wire tx_on   = ctl2_q[`ASTX_C2_TX_ON];
  wire rx_on   = ctl2_q[`ASTX_C2_RX_ON];
  wire send_break_ctl     = ctl2_q[`ASTX_C2_BREAK];
  wire standby = ctl2_q[`ASTX_C2_STANDBY];

  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;
  wire wr_c1   = wr & (paddr == `ASTX_CONTROL_ONE);
  wire wr_c2   = wr & (paddr == `ASTX_CONTROL_TWO);
  wire wr_c3   = wr & (paddr == `ASTX_CONTROL_THREE);
  wire wr_dat  = wr & (paddr == `ASTX_DATA_BUFFER);
  wire rd_s1   = rd & (paddr == `ASTX_STATUS_ONE);
  wire rd_dat  = rd & (paddr == `ASTX_DATA_BUFFER);

  // frame bit count: start + data (8 or 9) + parity? + stop
  function [3:0] frame_bits;
    input l9;
    input par;
    begin
      frame_bits = 4'd10 + {3'b000, l9} + {3'b000, par};
    end
  endfunction

  function odd_par;
    input [8:0] d;
    input       l9;
    begin
      odd_par = ^(l9 ? d : {1'b0, d[7:0]});
    end
  endfunction

  // shift word with the start bit in bit 0; ones shift in from the top,
  // so a twelve-bit frame picks up its stop bit that way
  function [10:0] tx_word;
    input [7:0] dat;
    input       ninth;
    input       l9;
    input       par_en;
    input       par;
    begin
      case ({l9, par_en})
        2'b11:   tx_word = {par, ninth, dat, 1'b0};
        2'b10:   tx_word = {1'b1, ninth, dat, 1'b0};
        2'b01:   tx_word = {1'b1, par, dat, 1'b0};
        default: tx_word = {2'b11, dat, 1'b0};
      endcase
    end
  endfunction

  // data sits lower in the receive shifter when more bits follow it
  function [7:0] rx_byte;
    input [10:0] sh;
    input        l9;
    input        par_en;
    begin
      case ({l9, par_en})
        2'b11:   rx_byte = sh[8:1];
        2'b10:   rx_byte = sh[9:2];
        2'b01:   rx_byte = sh[9:2];
        default: rx_byte = sh[10:3];
      endcase
    end
  endfunction

  wire [3:0] nbits = frame_bits(len9, ctl1_q[`ASTX_C1_PAR_EN]);
  wire       pbit  = odd_par({tx_buf_ninth_q, tx_buf_q}, len9) ^ ctl1_q[`ASTX_C1_PAR_ODD];

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  reg [31:0] rdata_d;
  reg        err_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    case (paddr)
      `ASTX_CONTROL_ONE:   rdata_d[7:0] = ctl1_q;
      `ASTX_CONTROL_TWO:   rdata_d[7:0] = ctl2_q;
      `ASTX_CONTROL_THREE: rdata_d[7:0] = {rx_ninth_q, ctl3_q};
      `ASTX_STATUS_ONE:    rdata_d[7:0] = {txe_q, tc_q, rxf_q, idle_q, 2'b00, fe_q, pe_q};
      `ASTX_STATUS_TWO:    rdata_d[7:0] = {6'h00, brk_q, rx_busy_q};
      `ASTX_DATA_BUFFER:   rdata_d[7:0] = rx_buf_q;
      default:             err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // registered ready: every access ends in its first access cycle
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : prdata;
      pslverr <= psel & ~penable & err_d;
    end
  end
  // writes and reads take effect only on the completing access edge
  wire done = acc & pready;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  wire wake_evt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_q <= `ASTX_C1_RST;
      ctl2_q <= `ASTX_C2_RST;
      ctl3_q <= `ASTX_C3_WR_RST;
    end else begin
      if (done & wr_c1)
        ctl1_q <= pwdata[7:0];
      if (done & wr_c3)
        ctl3_q <= pwdata[6:0];
      if (done & wr_c2) begin
        ctl2_q[7:4] <= pwdata[7:4];
        ctl2_q[1:0] <= pwdata[1:0];
        if (unit_on)
          ctl2_q[3:2] <= pwdata[3:2];
      end
      if (wake_evt & ~(done & wr_c2))
        ctl2_q[`ASTX_C2_STANDBY] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  wire tx_tick = baud_tick & unit_on;
  // the last tick of a character may load the next one, so breaks and
  // queued characters follow with no idle bit between them
  wire tx_last = tx_busy_q & tx_tick & (tx_cnt_q == 4'd1);
  // tx_on rising by a control_two write while the unit is on, busy or not
  wire re_on   = done & wr_c2 & unit_on & pwdata[`ASTX_C2_TX_ON] & ~tx_on;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q       <= 8'h00;
      tx_buf_ninth_q <= 1'b0;
      txe_q          <= 1'b1;
      tc_q           <= 1'b1;
      tx_sh_q        <= 11'h7ff;
      tx_cnt_q       <= 4'd0;
      tx_busy_q      <= 1'b0;
      pre_pend_q     <= 1'b0;
      idle_pend_q    <= 1'b0;
      tx_end_one_q   <= 1'b0;
    end else begin
      if (re_on) begin
        if (tx_busy_q)
          idle_pend_q <= 1'b1;
        else
          pre_pend_q <= 1'b1;
      end
      if (done & wr_dat) begin
        tx_buf_q       <= pwdata[7:0];
        tx_buf_ninth_q <= ctl3_q[`ASTX_C3_NINTH_TX];
        txe_q          <= 1'b0;
        tc_q           <= 1'b0;
      end
      if (tx_busy_q & tx_tick) begin
        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
        tx_cnt_q <= tx_cnt_q - 4'd1;
        if (tx_cnt_q == 4'd1)
          tx_busy_q <= 1'b0;
      end else if (~tx_busy_q | tx_last) begin
        // load decisions happen on an idle shifter or on the last tick of a character
      end
      if ((~tx_busy_q | tx_last) & tx_tick) begin
        if (send_break_ctl & tx_on) begin
          tx_sh_q      <= 11'h000;
          tx_cnt_q     <= nbits;
          tx_busy_q    <= 1'b1;
          tx_end_one_q <= 1'b1;
          pre_pend_q   <= 1'b0;
        end else if (tx_end_one_q) begin
          tx_sh_q      <= 11'h7ff;
          tx_cnt_q     <= 4'd1;
          tx_busy_q    <= 1'b1;
          tx_end_one_q <= 1'b0;
        end else if ((pre_pend_q | idle_pend_q) & tx_on) begin
          tx_sh_q     <= 11'h7ff;
          tx_cnt_q    <= nbits;
          tx_busy_q   <= 1'b1;
          pre_pend_q  <= 1'b0;
          idle_pend_q <= 1'b0;
        end else if (~txe_q & tx_on) begin
          tx_sh_q   <= tx_word(tx_buf_q, tx_buf_ninth_q, len9,
                               ctl1_q[`ASTX_C1_PAR_EN], pbit);
          tx_cnt_q  <= nbits;
          tx_busy_q <= 1'b1;
          txe_q     <= 1'b1;
        end else if (~tx_on | txe_q) begin
          tc_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  // one sample per tick, no oversampling: the rate generator places it
  wire rx_tick = baud_tick & unit_on & rx_on;
  wire [3:0] rx_len = nbits;
  wire rx_stop = rx_sh_q[10];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q      <= 11'h000;
      rx_cnt_q     <= 4'd0;
      rx_busy_q    <= 1'b0;
      rx_buf_q     <= 8'h00;
      rxf_q        <= 1'b0;
      idle_q       <= 1'b0;
      fe_q         <= 1'b0;
      pe_q         <= 1'b0;
      brk_q        <= 1'b0;
      fe_arm_q     <= 1'b0;
      pe_arm_q     <= 1'b0;
      rx_idle_q    <= 4'd0;
      idle_armed_q <= 1'b0;
      rx_ninth_q   <= 1'b0;
    end else begin
      // two-step clear: arm on status read, clear on buffer read; set wins
      if (done & rd_s1) begin
        fe_arm_q <= fe_q;
        pe_arm_q <= pe_q;
      end
      if (done & rd_dat) begin
        rxf_q <= 1'b0;
        if (fe_arm_q) fe_q <= 1'b0;
        if (pe_arm_q) pe_q <= 1'b0;
        fe_arm_q <= 1'b0;
        pe_arm_q <= 1'b0;
        brk_q    <= 1'b0;
        idle_q   <= 1'b0;
      end
      if (rx_tick) begin
        if (!rx_busy_q) begin
          if (!rx_pin_i) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q  <= rx_len - 4'd1;
            rx_sh_q   <= 11'h000;
          end else if (rx_idle_q != `ASTX_IDLE_BITS) begin
            rx_idle_q <= rx_idle_q + 4'd1;
          end else if (idle_armed_q) begin
            idle_q       <= 1'b1;
            idle_armed_q <= 1'b0;
          end
        end else begin
          rx_sh_q  <= {rx_pin_i, rx_sh_q[10:1]};
          rx_cnt_q <= rx_cnt_q - 4'd1;
          if (rx_cnt_q == 4'd1) begin
            rx_busy_q    <= 1'b0;
            rx_idle_q    <= 4'd0;
            idle_armed_q <= 1'b1;
            rxf_q        <= 1'b1;
            if (!rx_pin_i) begin
              fe_q <= 1'b1;
              if (rx_sh_q[10:3] == 8'h00 && (!len9 || !rx_sh_q[2])) begin
                brk_q     <= 1'b1;
                rx_buf_q  <= 8'h00;
                rx_ninth_q <= 1'b0;
              end
            end else begin
              rx_buf_q   <= rx_byte(rx_sh_q, len9, ctl1_q[`ASTX_C1_PAR_EN]);
              rx_ninth_q <= len9 & (ctl1_q[`ASTX_C1_PAR_EN] ? rx_sh_q[9] : rx_sh_q[10]);
              if (ctl1_q[`ASTX_C1_PAR_EN] &
                  ((len9 ? ^rx_sh_q[10:1] : ^rx_sh_q[10:2]) ^ ctl1_q[`ASTX_C1_PAR_ODD]))
                pe_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  wire unused_stop = rx_stop;
  // address mark: bit before the stop bit set in a completed frame (the parity bit when parity is on)
  assign wake_evt = standby & rx_tick & (ctl1_q[`ASTX_C1_WAKE_ADDR]
                    ? (rx_busy_q & (rx_cnt_q == 4'd1) & rx_sh_q[10] & unused_stop)
                    : (~rx_busy_q & rx_pin_i & (rx_idle_q == `ASTX_IDLE_BITS)));

  // ------------------------------------------------------------
  // pins and requests
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe   <= 1'b0;
      rx_pin_oe_n <= 1'b1;
      tx_irq      <= 1'b0;
      rx_irq      <= 1'b0;
      err_irq     <= 1'b0;
    end else begin
      tx_pin_o    <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      tx_pin_oe   <= unit_on;
      rx_pin_oe_n <= ~unit_on;
      tx_irq      <= txe_q & ctl2_q[`ASTX_C2_TXE_IE];
      rx_irq      <= ~standby & ((rxf_q & 1'b1) |
                     (idle_q & ctl2_q[`ASTX_C2_IDLE_IE]));
      err_irq     <= (fe_q & ctl3_q[`ASTX_C3_FE_IE]) |
                     (pe_q & ctl3_q[`ASTX_C3_PE_IE]);
    end
  end
endmodule

// file: astx_chk_assertions.sv
`timescale 1ns/1ps
`include "astx_regs.vh"
module astx_chk (
  input wire        pclk,        // bus clock
  input wire        presetn,     // reset, low
  input wire        psel,        // select
  input wire        penable,     // access phase
  input wire        pwrite,      // direction
  input wire [11:0] paddr,       // address
  input wire [31:0] pwdata,      // write data
  input wire [31:0] prdata,      // read data
  input wire        pready,      // ready
  input wire        pslverr,     // error
  input wire        baud_tick,   // bit enable
  input wire        rx_pin_i,    // rx level
  input wire        tx_pin_o,    // tx level
  input wire        tx_pin_oe,   // tx driven
  input wire        rx_pin_oe_n, // rx owned, low
  input wire        tx_irq,      // tx request
  input wire        rx_irq,      // rx request
  input wire        err_irq      // error request
);
  // ------------------------------------------------------------
  // bus, line and request relations
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  property p_ready; psel && !penable |=> pready; endproperty
  property p_access; pready |-> psel && penable; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_unmapped; pready && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  // registered pin: a move shows two samples after the bit tick
  property p_tick;
    tx_pin_oe && $past(tx_pin_oe) && $changed(tx_pin_o) |-> $past(baud_tick, 2);
  endproperty
  property p_unit_off;
    s_wr(`ASTX_CONTROL_ONE) ##0 !pwdata[`ASTX_C1_UNIT_ON] |-> ##2 !tx_pin_oe && rx_pin_oe_n;
  endproperty
  property p_txie; s_wr(`ASTX_CONTROL_TWO) ##0 !pwdata[7] |-> ##2 !tx_irq; endproperty
  property p_errie; s_wr(`ASTX_CONTROL_THREE) ##0 pwdata[1:0] == 2'b00 |-> ##2 !err_irq; endproperty
  property p_standby; s_wr(`ASTX_CONTROL_TWO) ##0 pwdata[1] |-> ##2 !rx_irq; endproperty
  property p_reset_idle; $rose(presetn) |-> tx_pin_o && !tx_pin_oe; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  a_access: assert property (p_access) else $error("pready outside access");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_tick: assert property (p_tick) else $error("tx moved off tick");
  a_unit_off: assert property (p_unit_off) else $error("pins kept");
  a_txie: assert property (p_txie) else $error("tx irq unmasked");
  a_errie: assert property (p_errie) else $error("err irq unmasked");
  a_standby: assert property (p_standby) else $error("rx irq in standby");
  a_reset_idle: assert property (p_reset_idle) else $error("tx not idle");
endmodule

// file: astx_peer.sv
`timescale 1ns/1ps
module astx_peer (
  input  wire pclk,      // bus clock
  input  wire baud_tick, // bit enable
  input  wire tx_line,   // from device, pulled up
  output reg  rx_line    // into device
);
  // ------------------------------------------------------------
  // one bit per tick both ways
  // ------------------------------------------------------------
  initial rx_line = 1'b1;
  task tick;
    @(posedge pclk);
    while (baud_tick !== 1'b1) @(posedge pclk);
  endtask
  task get_bit(output logic b);
    tick;
    b = tx_line;
  endtask
  // lsb first; the line rests high between frames
  task send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      tick;
      rx_line <= f[i];
    end
    tick;
    rx_line <= 1'b1;
  endtask
endmodule

// file: async_serial_tx_break_flags_test.sv
`timescale 1ns/1ps
`include "astx_regs.vh"
module async_serial_tx_break_flags_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         baud_tick = 1'b0;
  reg  [3:0]  bdiv = 4'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, rx_pin_i, tx_pin_o, tx_pin_oe, rx_pin_oe_n;
  wire        tx_irq, rx_irq, err_irq;
  wire        tx_wire = tx_pin_oe ? tx_pin_o : 1'b1;
  int         n_mismatch = 0;
  int         compares = 0;
  int         cyc = 0;
  int         n, t0;
  reg  [31:0] seed = 32'd59;
  reg  [31:0] rd;
  reg         err, b;
  reg  [7:0]  d;
  reg  [9:0]  v;
  astx_core astx_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .baud_tick, .rx_pin_i, .tx_pin_o, .tx_pin_oe, .rx_pin_oe_n,
    .tx_irq, .rx_irq, .err_irq);
  astx_peer astx_peer_inst (.pclk, .baud_tick, .tx_line(tx_wire), .rx_line(rx_pin_i));
  always #20 pclk = ~pclk;
  // slow bit rate leaves room for a bus access between ticks
  always @(posedge pclk) begin
    bdiv <= bdiv + 4'h1;
    baud_tick <= (bdiv == 4'hf);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [9:0] frame(input [7:0] x);
    frame = {1'b1, x, 1'b0};
  endfunction
  task check(input [31:0] seen, input [31:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input reg w, input [11:0] a, input [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_start;
    int k;
    k = 0;
    b = 1'b1;
    while (b !== 1'b0 && k < 60) begin
      astx_peer_inst.get_bit(b);
      k = k + 1;
    end
  endtask
  task rest9;
    v = 10'h0;
    for (int i = 1; i < 10; i++) astx_peer_inst.get_bit(v[i]);
  endtask
  task tdone(input string s);
    $display("test %0s done", s);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ASTX_CONTROL_TWO, 0);
    check(rd, `ASTX_C2_RST, "control_two");
    apb(0, `ASTX_STATUS_ONE, 0);
    check(rd[7], 1, "txe reset");
    check(tx_pin_o, 1, "tx idle");
    apb(0, 12'h018, 0);
    check(err, 1, "unmapped error");
    check(rd, 0, "unmapped data");
    apb(1, `ASTX_CONTROL_TWO, 32'h0c);
    apb(0, `ASTX_CONTROL_TWO, 0);
    check(rd[3:2], 0, "gated enables");
    tdone("reset");
    apb(1, `ASTX_CONTROL_ONE, 32'h40);
    astx_peer_inst.get_bit(b);
    apb(1, `ASTX_CONTROL_TWO, 32'h88);
    t0 = cyc;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 8'h00 : seed[7:0];
      apb(0, `ASTX_STATUS_ONE, 0);
      apb(1, `ASTX_DATA_BUFFER, {24'h0, d});
      if (i == 0) begin
        apb(0, `ASTX_STATUS_ONE, 0);
        check(rd[7], 0, "txe held");
      end
      wait_start;
      if (i == 0) check(cyc - t0 >= 170 && cyc - t0 <= 210, 1, "preamble");
      if (i == 2) apb(1, `ASTX_CONTROL_TWO, 32'h80);
      rest9;
      check(v, frame(d), "tx frame");
    end
    check(tx_irq, 1, "tx irq");
    tdone("transmit");
    apb(1, `ASTX_CONTROL_TWO, 32'h89);
    wait_start;
    n = 1;
    while (b === 1'b0 && n < 70) begin
      astx_peer_inst.get_bit(b);
      if (b === 1'b0) n = n + 1;
      if (n == 25 && b === 1'b0) apb(1, `ASTX_CONTROL_TWO, 32'h88);
    end
    check(n, 30, "break run");
    check(b, 1, "after break");
    tdone("break");
    apb(1, `ASTX_CONTROL_TWO, 32'h8c);
    apb(1, `ASTX_CONTROL_THREE, 32'h02);
    seed = xs(seed);
    d = seed[7:0];
    astx_peer_inst.send(frame(d));
    repeat (2) astx_peer_inst.get_bit(b);
    apb(1, `ASTX_CONTROL_TWO, 32'h88);
    apb(0, `ASTX_STATUS_ONE, 0);
    check(rd[5], 1, "rx full kept");
    apb(0, `ASTX_DATA_BUFFER, 0);
    check(rd, {24'h0, d}, "rx data");
    apb(1, `ASTX_CONTROL_TWO, 32'h8c);
    astx_peer_inst.send(10'h000);
    repeat (2) astx_peer_inst.get_bit(b);
    check(err_irq, 1, "err irq");
    check(rx_irq, 1, "rx irq");
    apb(0, `ASTX_STATUS_TWO, 0);
    check(rd[1], 1, "break seen");
    apb(0, `ASTX_STATUS_ONE, 0);
    check({rd[5], rd[1]}, 2'b11, "break flags");
    apb(0, `ASTX_DATA_BUFFER, 0);
    check(rd, 0, "break data");
    apb(0, `ASTX_STATUS_ONE, 0);
    check(rd[1], 0, "fe cleared");
    tdone("receive");
    apb(1, `ASTX_CONTROL_THREE, 0);
    apb(1, `ASTX_CONTROL_TWO, 32'h06);
    apb(1, `ASTX_CONTROL_ONE, 0);
    repeat (2) @(posedge pclk);
    check({tx_pin_oe, rx_pin_oe_n}, 2'b01, "pins released");
    tdone("release");
    stop_test;
  end
endmodule
bind astx_core astx_chk astx_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .baud_tick, .rx_pin_i, .tx_pin_o, .tx_pin_oe,
  .rx_pin_oe_n, .tx_irq, .rx_irq, .err_irq);
